/* File: logic/rivec_map.vh */
// register offsets, field positions, vectors and the config load length for the vectoring unit
`ifndef RIVEC_MAP_VH
`define RIVEC_MAP_VH
// register byte addresses (word aligned)
`define RIVEC_OFS_WDOG 8'h3C
`define RIVEC_OFS_VBASE 8'h40
`define RIVEC_OFS_ENABLE 8'h44
`define RIVEC_OFS_CTRL 8'h48
`define RIVEC_OFS_VECTOR 8'h4C
`define RIVEC_OFS_STATUS 8'h50
// watchdog_control fields
`define RIVEC_WD_RATE_MSB 2
`define RIVEC_WD_WIN_BIT 7
// ctrl fields: mask bits and oscillator enable
`define RIVEC_CTRL_I_BIT 0
`define RIVEC_CTRL_X_BIT 1
`define RIVEC_CTRL_OSC_BIT 2
// enable fields
`define RIVEC_EN_LINK 0
`define RIVEC_EN_TICK 1
`define RIVEC_EN_SRX 2
`define RIVEC_EN_STX 3
`define RIVEC_EN_OSC 4
`define RIVEC_EN_PLL 5
`define RIVEC_EN_SFD 6
`define RIVEC_EN_DFD 7
`define RIVEC_EN_CMD 8
`define RIVEC_EN_UV 9
// reset values
`define RIVEC_VBASE_RST 8'hFF
`define RIVEC_CTRL_RST 3'h3
// fixed reset vectors
`define RIVEC_VEC_MAIN 16'hFFFE
`define RIVEC_VEC_CLKMON 16'hFFFC
`define RIVEC_VEC_WDOG 16'hFFFA
// interrupt offsets
`define RIVEC_OF_TRAP 8'hF8
`define RIVEC_OF_SWI 8'hF6
`define RIVEC_OF_LINKI 8'hF4
`define RIVEC_OF_LINKE 8'hF2
`define RIVEC_OF_TICK 8'hF0
`define RIVEC_OF_SER 8'hD8
`define RIVEC_OF_OSC 8'hC8
`define RIVEC_OF_PLL 8'hC6
`define RIVEC_OF_FERR 8'hBA
`define RIVEC_OF_FCMD 8'hB8
`define RIVEC_OF_UV 8'h8A
`define RIVEC_OF_SPUR 8'h80
// option byte location in the nonvolatile array
`define RIVEC_OPT_ADDR 18'h3FF0E
// configuration load length in nonvolatile words
`define RIVEC_CFG_WORDS 4
`endif

/* File: logic/rivec_prio.v */
// fixed-priority encoder for interrupt requests
`timescale 1ns/1ns
module rivec_prio
#(
  parameter N = 12
)
(
  input wire [N-1:0] req,
  input wire [8*N-1:0] offs,
  output reg [7:0] offset,
  output reg found
);
  integer i;
  // index 0 is highest priority; offsets are listed in falling order
  always @*
  begin
    offset = 8'h00;
    found = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        offset = offs[8*i +: 8];
        found = 1'b1;
      end
    end
  end
endmodule // rivec_prio

/* File: logic/rivec_top.v */
// reset and interrupt vectoring unit with config load and watchdog init
// What this block does
// RL1: power-on, undervolt, pin and illegal-address resets fetch vector FFFE, unmaskable
// RL2: clock monitor reset uses FFFC, active only with oscillator enable bit set
// RL3: watchdog reset uses FFFA, enabled by nonzero watchdog rate field
// RL4: interrupt vector equals software vector base plus fixed per-source offset
// RL5: pending interrupts served by default order, higher offset wins
// RL6: trap and SWI unmaskable at F8/F6; link internal error F4 masked by X
// RL7: link external error F2 masked by I, gated by link enable, wakes stop
// RL8: I-maskable sources each have own offset and local enable
// RL9: spurious vector at offset 80 with no enable; other offsets reserved
// RL10: every fetched vector is a 16-bit address word
// RL11: every reset stalls the CPU until flash configuration is loaded; only sys_rst stalls, the RL1-RL3 resets do not
// RL12: double fault during config load leaves protection and security on
// RL13: reset during program or erase aborts that command at once; flash_abort rises only after sys_rst release, not on RL1-RL3 resets
// RL14: reset never clears on-chip RAM contents
// RL15: option register loaded from fixed option byte, then watchdog fields
// RL16: initial watchdog rate is inverse of low three option bits
// RL17: initial window mode bit is inverse of option bit 3
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "rivec_map.vh"
module rivec_top
#(
  parameter CFG_WORDS = `RIVEC_CFG_WORDS
)
(
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [3:0] rst_cause,
  input wire clkmon_fail,
  input wire wdog_timeout,
  input wire [9:0] irq_src,
  input wire trap_req,
  input wire swi_req,
  input wire in_stop,
  input wire flash_busy,
  output reg [17:0] nv_addr,
  output reg nv_rd,
  input wire [7:0] nv_data,
  input wire nv_valid,
  input wire nv_dfault,
  output reg cpu_stall,
  output reg flash_abort,
  output reg prot_force,
  output reg [15:0] vector,
  output reg vector_valid,
  output reg irq_pending,
  output reg wake_req,
  output reg [7:0] option_q,
  output reg reset_req
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam SW = 17;
  reg [SW-1:0] sy1_q;
  reg [SW-1:0] sy2_q;
  wire [SW-1:0] sy_in;
  assign sy_in = {in_stop, clkmon_fail, wdog_timeout, rst_cause[3:0], irq_src};
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sy1_q <= {SW{1'b0}};
      sy2_q <= {SW{1'b0}};
    end
    else
    begin
      sy1_q <= sy_in;
      sy2_q <= sy1_q;
    end
  end
  wire [9:0] src_s = sy2_q[9:0];
  wire any_main = |sy2_q[13:10];
  wire wdog_s = sy2_q[14];
  wire clkm_s = sy2_q[15];
  wire stop_s = sy2_q[16];

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [2:0] wd_rate_q;
  reg wd_win_q;
  reg [7:0] vbase_q;
  reg [9:0] en_q;
  reg [2:0] ctrl_q;
  wire i_mask = ctrl_q[`RIVEC_CTRL_I_BIT];
  wire x_mask = ctrl_q[`RIVEC_CTRL_X_BIT];
  wire osc_enable_bit = ctrl_q[`RIVEC_CTRL_OSC_BIT];

  // ****************************************************************
  // reset source selection
  // ****************************************************************
  wire clkm_hit = clkm_s & osc_enable_bit; // RL2
  wire wdog_hit = wdog_s & (|wd_rate_q); // RL3
  reg [15:0] rst_vec_d;
  always @*
  begin
    if (any_main)
      rst_vec_d = `RIVEC_VEC_MAIN; // RL1
    else if (clkm_hit)
      rst_vec_d = `RIVEC_VEC_CLKMON; // RL2
    else
      rst_vec_d = `RIVEC_VEC_WDOG; // RL3
  end
  wire rst_hit = any_main | clkm_hit | wdog_hit;

  // ****************************************************************
  // interrupt arbitration
  // ****************************************************************
  wire [11:0] req;
  assign req[0] = trap_req; // RL6
  assign req[1] = swi_req; // RL6
  assign req[2] = src_s[0] & ~x_mask; // RL6
  assign req[3] = src_s[1] & ~i_mask & en_q[`RIVEC_EN_LINK]; // RL7
  assign req[4] = src_s[2] & ~i_mask & en_q[`RIVEC_EN_TICK]; // RL8
  assign req[5] = src_s[3] & ~i_mask & (en_q[`RIVEC_EN_SRX] | en_q[`RIVEC_EN_STX]); // RL8
  assign req[6] = src_s[4] & ~i_mask & en_q[`RIVEC_EN_OSC]; // RL8
  assign req[7] = src_s[5] & ~i_mask & en_q[`RIVEC_EN_PLL]; // RL8
  assign req[8] = src_s[6] & ~i_mask & (en_q[`RIVEC_EN_SFD] | en_q[`RIVEC_EN_DFD]); // RL8
  assign req[9] = src_s[7] & ~i_mask & en_q[`RIVEC_EN_CMD]; // RL8
  assign req[10] = src_s[8] & ~i_mask & en_q[`RIVEC_EN_UV]; // RL8
  assign req[11] = src_s[9]; // RL9
  // falling offsets give the default order, higher offset wins
  wire [95:0] offs = {`RIVEC_OF_SPUR, `RIVEC_OF_UV, `RIVEC_OF_FCMD, `RIVEC_OF_FERR,
    `RIVEC_OF_PLL, `RIVEC_OF_OSC, `RIVEC_OF_SER, `RIVEC_OF_TICK, `RIVEC_OF_LINKE,
    `RIVEC_OF_LINKI, `RIVEC_OF_SWI, `RIVEC_OF_TRAP}; // RL5
  wire [7:0] win_off;
  wire win_found;
  rivec_prio #(.N(12)) u_prio
  (
    .req(req),
    .offs(offs),
    .offset(win_off),
    .found(win_found)
  );
  // only the die link errors and the tick may wake from stop
  wire wake_d = stop_s & (req[2] | req[3] | req[4]); // RL7

  // ****************************************************************
  // configuration load sequence
  // ****************************************************************
  localparam ST_LOAD = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;
  reg [2:0] st_q;
  reg [7:0] cnt_q;
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_LOAD;
      cnt_q <= 8'h00;
      cpu_stall <= 1'b1; // RL11
      nv_rd <= 1'b0;
      nv_addr <= 18'h00000;
      option_q <= 8'hFF;
      prot_force <= 1'b0;
      vector <= 16'h0000;
      vector_valid <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_LOAD:
        begin
          nv_addr <= `RIVEC_OPT_ADDR; // RL15
          nv_rd <= 1'b1;
          st_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (nv_valid)
          begin
            option_q <= nv_data; // RL15
            if (nv_dfault)
              prot_force <= 1'b1; // RL12
            // strobe stays up until the last word, however long the array takes to answer
            if (cnt_q == CFG_WORDS[7:0] - 8'h01)
            begin
              nv_rd <= 1'b0;
              st_q <= ST_RUN;
              cpu_stall <= 1'b0; // RL11
            end
            else
              cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_RUN:
        begin
          if (rst_hit)
          begin
            vector <= rst_vec_d; // RL1
            vector_valid <= 1'b1;
          end
          else if (win_found)
          begin
            vector <= {vbase_q, win_off}; // RL4 RL10
            vector_valid <= 1'b1;
          end
          else
            vector_valid <= 1'b0;
        end
        default:
          st_q <= ST_LOAD;
      endcase
    end
  end
  wire load_done = (st_q == ST_WAIT) & nv_valid & (cnt_q == CFG_WORDS[7:0] - 8'h01);

  // ****************************************************************
  // status outputs
  // ****************************************************************
  // abort holds over the whole load phase, so a command still busy late
  // in the stall is cut short as well
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flash_abort <= 1'b0;
      reset_req <= 1'b0;
      irq_pending <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      flash_abort <= flash_busy & (st_q != ST_RUN); // RL13
      reset_req <= rst_hit & (st_q == ST_RUN); // RL1
      irq_pending <= win_found & (st_q == ST_RUN); // RL5
      wake_req <= wake_d; // RL7
    end
  end

  // ****************************************************************
  // read data decode
  // ****************************************************************
  reg [31:0] rdata_d;
  always @*
  begin
    rdata_d = 32'h00000000;
    if (avs_address == `RIVEC_OFS_WDOG)
      rdata_d = {24'h000000, wd_win_q, 4'h0, wd_rate_q};
    else if (avs_address == `RIVEC_OFS_VBASE)
      rdata_d = {24'h000000, vbase_q};
    else if (avs_address == `RIVEC_OFS_ENABLE)
      rdata_d = {22'h000000, en_q};
    else if (avs_address == `RIVEC_OFS_CTRL)
      rdata_d = {29'h00000000, ctrl_q};
    else if (avs_address == `RIVEC_OFS_VECTOR)
      rdata_d = {16'h0000, vector};
    else if (avs_address == `RIVEC_OFS_STATUS)
      rdata_d = {20'h00000, option_q, 1'b0, prot_force, cpu_stall, vector_valid};
  end

  // ****************************************************************
  // register slave, one wait state on every access
  // ****************************************************************
  reg acc_q;
  wire acc = (avs_read | avs_write) & ~acc_q;
  wire wr_go = avs_write & acc_q;
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      wd_rate_q <= 3'h0;
      wd_win_q <= 1'b0;
      vbase_q <= `RIVEC_VBASE_RST;
      en_q <= 10'h000;
      ctrl_q <= `RIVEC_CTRL_RST;
    end
    else
    begin
      acc_q <= acc;
      avs_waitrequest <= ~acc;
      if (load_done)
      begin
        wd_rate_q <= ~nv_data[2:0]; // RL16
        wd_win_q <= ~nv_data[3]; // RL17
      end
      else if (wr_go && avs_address == `RIVEC_OFS_WDOG)
      begin
        wd_rate_q <= avs_writedata[`RIVEC_WD_RATE_MSB:0];
        wd_win_q <= avs_writedata[`RIVEC_WD_WIN_BIT];
      end
      if (wr_go && avs_address == `RIVEC_OFS_VBASE)
        vbase_q <= avs_writedata[7:0]; // RL4
      if (wr_go && avs_address == `RIVEC_OFS_ENABLE)
        en_q <= avs_writedata[9:0];
      if (wr_go && avs_address == `RIVEC_OFS_CTRL)
        ctrl_q <= avs_writedata[2:0];
      if (acc)
        avs_readdata <= rdata_d;
    end
  end
  // on-chip RAM lies outside this unit and is never touched by reset RL14
endmodule // rivec_top

/* File: verif/rivec_nv_model.sv */
// nonvolatile array model that answers configuration reads
`timescale 1ns/1ns
module rivec_nv_model
#(
  parameter [3:0] DLY = 4'h3
)
(
  input wire ref_clk,
  input wire sys_rst,
  input wire nv_rd,
  input wire [7:0] opt,
  input wire dfault,
  output reg [7:0] nv_data,
  output reg nv_valid,
  output reg nv_dfault
);
  reg [3:0] cnt_q;
  // every word returns the option byte, so the last word loaded is always it
  always @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      nv_valid <= 1'b0;
      nv_dfault <= 1'b0;
      nv_data <= 8'hA5;
    end
    else if (nv_rd && !nv_valid && cnt_q == DLY)
    begin
      cnt_q <= 4'h0;
      nv_valid <= 1'b1;
      nv_dfault <= dfault;
      nv_data <= opt;
    end
    else
    begin
      cnt_q <= nv_rd ? cnt_q + 4'h1 : 4'h0;
      nv_valid <= 1'b0;
      nv_dfault <= 1'b0;
      // data is held for the valid cycle only, then inverts every clock
      nv_data <= ~nv_data;
    end
endmodule // rivec_nv_model

/* File: verif/rivec_assertions.sv */
// port checker for the vectoring unit
`timescale 1ns/1ns
module rivec_assertions
(
  input wire ref_clk,
  input wire sys_rst,
  input wire [3:0] rst_cause,
  input wire clkmon_fail,
  input wire wdog_timeout,
  input wire [9:0] irq_src,
  input wire trap_req,
  input wire flash_busy,
  input wire [17:0] nv_addr,
  input wire nv_rd,
  input wire nv_valid,
  input wire nv_dfault,
  input wire cpu_stall,
  input wire flash_abort,
  input wire prot_force,
  input wire [15:0] vector,
  input wire vector_valid,
  input wire wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_calm;
    (rst_cause == 4'h0 && !clkmon_fail && !wdog_timeout && !cpu_stall) [*4];
  endsequence
  sequence s_main;
    (rst_cause != 4'h0 && !cpu_stall) [*4];
  endsequence
  chk_stall_hold: assert property ($past(sys_rst) |-> cpu_stall)
    else $error("stall low right after reset");
  chk_stall_end: assert property ($fell(cpu_stall) |-> $past(nv_valid) || $past(nv_valid, 2))
    else $error("stall ended without a config word");
  chk_nv_start: assert property ($rose(nv_rd) |-> nv_addr == 18'h3FF0E)
    else $error("config read from wrong address");
  chk_prot_set: assert property (nv_valid && nv_dfault && cpu_stall |=> prot_force)
    else $error("double fault did not force protection");
  chk_abort_set: assert property (flash_busy && cpu_stall ##1 cpu_stall |-> ##[0:1] flash_abort)
    else $error("busy flash not aborted");
  chk_abort_idle: assert property (!cpu_stall && !$past(cpu_stall) |-> !flash_abort)
    else $error("abort outside reset");
  chk_main_vec: assert property (s_main |-> vector_valid && vector == 16'hFFFE)
    else $error("reset vector wrong");
  chk_trap_vec: assert property ((s_calm and trap_req [*4]) |-> vector[7:0] == 8'hF8)
    else $error("trap offset wrong");
  chk_wake_only: assert property ((irq_src[2:0] == 3'h0) [*4] |-> !wake_req)
    else $error("wake from a non-waking source");
endmodule // rivec_assertions
bind rivec_top rivec_assertions u_chk (.*);

/* File: verif/reset_interrupt_vectoring_bench.sv */
// self-checking bench for the vectoring unit
`timescale 1ns/1ns
`define CHK(n, e, s) \
  begin \
    total_checks++; \
    if ((s) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, s); \
    end \
  end
module reset_interrupt_vectoring_bench;
  reg ref_clk, sys_rst, avs_read, avs_write, clkmon_fail, wdog_timeout;
  reg trap_req, swi_req, in_stop, flash_busy, dfault;
  reg [7:0] avs_address, opt;
  reg [31:0] avs_writedata, rdat;
  reg [3:0] rst_cause;
  reg [9:0] irq_src;
  wire [31:0] avs_readdata;
  wire [17:0] nv_addr;
  wire [7:0] nv_data, option_q;
  wire [15:0] vector;
  wire avs_waitrequest, nv_rd, nv_valid, nv_dfault, cpu_stall, flash_abort;
  wire prot_force, vector_valid, irq_pending, wake_req, reset_req;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] ofs [10] = '{8'hF4, 8'hF2, 8'hF0, 8'hD8, 8'hC8, 8'hC6, 8'hBA, 8'hB8, 8'h8A, 8'h80};
  rivec_top #(.CFG_WORDS(2)) dut (.*);
  rivec_nv_model nvm (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ************
  // bus accesses
  // ************
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    // registered outputs still show their pre-edge value here
    while (avs_waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 40)
      fail_count++;
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK("register", e, rdat)
  endtask
  task automatic vec(input logic [15:0] e);
    repeat (6) @(posedge ref_clk);
    `CHK("vector", e, vector)
  endtask
  task automatic boot(input logic [7:0] o, input logic df);
    int n;
    n = 0;
    {sys_rst, avs_read, avs_write, trap_req, swi_req} <= 5'h10;
    {clkmon_fail, wdog_timeout, in_stop, rst_cause, irq_src} <= 17'h0;
    {avs_address, avs_writedata} <= 40'h0;
    {opt, dfault, flash_busy} <= {o, df, df};
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("stall", 1'b1, cpu_stall)
    `CHK("abort", df, flash_abort)
    flash_busy <= 1'b0;
    while (cpu_stall !== 1'b0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("prot", df, prot_force)
    `CHK("option", o, option_q)
  endtask
  // *********
  // sequences
  // *********
  initial
  begin
    boot(8'h05, 1'b0);
    rd(8'h3C, 32'h82);
    rd(8'h40, 32'hFF);
    rd(8'h48, 32'h3);
    rd(8'hFC, 32'h0);
    acc(1'b1, 8'h40, 32'h12);
    acc(1'b1, 8'h44, 32'h3FF);
    acc(1'b1, 8'h48, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      irq_src <= 10'h001 << i;
      vec({8'h12, ofs[i]});
    end
    in_stop <= 1'b1;
    vec(16'h1280);
    `CHK("wake", 1'b0, wake_req)
    irq_src <= 10'h3FF;
    vec(16'h12F4);
    `CHK("wake", 1'b1, wake_req)
    `CHK("pending", 1'b1, irq_pending)
    `CHK("reset", 1'b0, reset_req)
    rd(8'h4C, 32'h12F4);
    rd(8'h50, 32'h51);
    {trap_req, swi_req} <= 2'h3;
    vec(16'h12F8);
    trap_req <= 1'b0;
    vec(16'h12F6);
    swi_req <= 1'b0;
    acc(1'b1, 8'h48, 32'h3);
    vec(16'h1280);
    {wdog_timeout, clkmon_fail} <= 2'h3;
    vec(16'hFFFA);
    acc(1'b1, 8'h48, 32'h4);
    vec(16'hFFFC);
    rst_cause <= 4'h8;
    vec(16'hFFFE);
    `CHK("reset", 1'b1, reset_req)
    boot(8'h08, 1'b1);
    rd(8'h3C, 32'h07);
    rd(8'h50, 32'h84);
    test_done;
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    test_done;
  end
endmodule // reset_interrupt_vectoring_bench
